//--- logic/sat_adc_ctrl.sv
// Converter timing and sequencing block with its Wishbone register file.
// Assumes a classic Wishbone master, one clock and an analog front end
// that presents a settled result when the conversion time has passed.
//
// Our own choices: the placing of the registers and the Wishbone register port.

`timescale 1ns/1ps

module sat_adc_ctrl (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt.
    output logic irq_o,
    // Triggers and clock source.
    input wire logic trig_i,
    input wire logic rc_tick_i,
    // Analog front end.
    input wire logic [11:0] conv_result_i,
    output logic sample_o,
    output logic convert_o,
    output logic [1:0] conv_sh_o,
    output logic [1:0] sh_count_o,
    output logic [3:0] chan_sel_o,
    output logic [2:0] vref_sel_o,
    output logic res12_o,
    output logic [9:0] pin_digital_o
);
    typedef struct packed {
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] c3;
        logic [15:0] pl;
        logic [15:0] ph;
        logic [15:0] chs;
        logic [1:0] st;
        logic [1:0] mask;
        logic [15:0][15:0] rbuf;
        logic [3:0] widx;
        logic [3:0] nsmp;
        logic [4:0] tadc;
        logic [1:0] shi;
        logic [1:0] shc;
        logic [8:0] gap;
        sat_pkg::sat_fsm_e fsm;
        logic ack;
        logic irq;
        logic sample;
        logic convert;
        logic [31:0] rdat;
    } sat_state_s;

    sat_state_s s_r;
    sat_state_s s_nxt;
    logic conversion_clock_period;

    ////////////////////////////////////////////////////////////////////////////

    // Conversion clock keeps running whatever the processor power state.
    sat_tad_gen u_tad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(s_r.c1[sat_pkg::C1_ON]),
        .rc_sel_i(s_r.c3[sat_pkg::C3_RC]),
        .div_i(s_r.c3[sat_pkg::C3_DIV +: 8]),
        .rc_tick_i(rc_tick_i),
        .tad_o(conversion_clock_period)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Merges the written byte lanes into a 16-bit register.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [15:0] v;
        v = old;
        if (sel[0]) begin
            v[7:0] = d[7:0];
        end
        if (sel[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction

    // Places a raw result in the buffer word in the chosen format.
    function automatic logic [15:0] fmt(input logic [11:0] d,
                                        input logic r12,
                                        input logic [1:0] f);
        logic [15:0] v;
        v = 16'h0000;
        unique case (f)
            2'h0: v = r12 ? {4'h0, d} : {6'h00, d[9:0]};
            2'h1: v = r12 ? {{5{~d[11]}}, d[10:0]}
                          : {{7{~d[9]}}, d[8:0]};
            2'h2: v = r12 ? {d, 4'h0} : {d[9:0], 6'h00};
            2'h3: v = r12 ? {~d[11], d[10:0], 4'h0}
                          : {~d[9], d[8:0], 6'h00};
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    logic req;
    logic on;
    logic r12;
    logic [2:0] trig_src;
    logic start;
    logic [2:0] nsh;
    logic [4:0] conv_len;
    logic [8:0] min_gap;
    logic [15:0] wv;

    always_comb begin
        s_nxt = s_r;
        req = wb_cyc_i && wb_stb_i && !s_r.ack;
        on = s_r.c1[sat_pkg::C1_ON];
        r12 = s_r.c1[sat_pkg::C1_RES];
        trig_src = s_r.c1[sat_pkg::C1_TRIG +: 3];
        wv = 16'h0000;
        if (r12) begin
            nsh = 3'h1;
            conv_len = sat_pkg::CONV_TAD12;
            min_gap = 9'(sat_pkg::MIN_CYC12);
        end else begin
            unique case (s_r.c2[sat_pkg::C2_SHC +: 2])
                2'h0: nsh = 3'h1;
                2'h1: nsh = 3'h2;
                default: nsh = 3'h4;
            endcase
            conv_len = sat_pkg::CONV_TAD10;
            min_gap = 9'(sat_pkg::MIN_CYC10);
        end

        // Bus slave: one wait state, ack for one cycle, unmapped reads zero.
        s_nxt.ack = req;
        s_nxt.rdat = 32'h0000_0000;
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                sat_pkg::OFF_CTRL1: begin
                    wv = merge(s_r.c1, wb_dat_i, wb_sel_i);
                    if (on) begin
                        wv[sat_pkg::C1_RES] = r12;
                    end
                    s_nxt.c1 = wv;
                end
                sat_pkg::OFF_CTRL2: begin
                    s_nxt.c2 = merge(s_r.c2, wb_dat_i, wb_sel_i);
                end
                sat_pkg::OFF_CTRL3: begin
                    s_nxt.c3 = merge(s_r.c3, wb_dat_i, wb_sel_i)
                        & sat_pkg::C3_IMPL;
                end
                sat_pkg::OFF_PCFGL: begin
                    s_nxt.pl = merge(s_r.pl, wb_dat_i, wb_sel_i);
                end
                sat_pkg::OFF_PCFGH: begin
                    s_nxt.ph = merge(s_r.ph, wb_dat_i, wb_sel_i);
                end
                sat_pkg::OFF_MASK: begin
                    if (wb_sel_i[0]) begin
                        s_nxt.mask = wb_dat_i[1:0];
                    end
                end
                sat_pkg::OFF_CHSEL: begin
                    wv = merge(s_r.chs, wb_dat_i, wb_sel_i);
                    if (wv[3:0] > sat_pkg::CHAN_MAX) begin
                        wv[3:0] = sat_pkg::CHAN_MAX;
                    end
                    s_nxt.chs = {12'h000, wv[3:0]};
                end
                default: ;
            endcase
        end else if (req) begin
            unique case (wb_adr_i)
                sat_pkg::OFF_CTRL1: s_nxt.rdat = {16'h0000, s_r.c1};
                sat_pkg::OFF_CTRL2: s_nxt.rdat = {16'h0000, s_r.c2};
                sat_pkg::OFF_CTRL3: s_nxt.rdat = {16'h0000, s_r.c3};
                sat_pkg::OFF_PCFGL: s_nxt.rdat = {16'h0000, s_r.pl};
                sat_pkg::OFF_PCFGH: s_nxt.rdat = {16'h0000, s_r.ph};
                sat_pkg::OFF_STAT: begin
                    s_nxt.rdat = {30'h0000_0000, s_r.st};
                    s_nxt.st = 2'h0;
                end
                sat_pkg::OFF_MASK: s_nxt.rdat = {30'h0000_0000, s_r.mask};
                sat_pkg::OFF_CHSEL: s_nxt.rdat = {16'h0000, s_r.chs};
                default: begin
                    if (wb_adr_i[7:6] == sat_pkg::BUF_PAGE) begin
                        s_nxt.rdat = {16'h0000, s_r.rbuf[wb_adr_i[5:2]]};
                    end
                end
            endcase
        end

        // Sequencer.
        if (s_r.gap != 9'h000) begin
            s_nxt.gap = s_r.gap - 9'h001;
        end
        unique case (trig_src)
            sat_pkg::TRIG_MANUAL: start = s_r.c1[sat_pkg::C1_GO];
            sat_pkg::TRIG_EXT: start = trig_i;
            sat_pkg::TRIG_AUTO: start = 1'b1;
            default: start = 1'b0;
        endcase
        unique case (s_r.fsm)
            sat_pkg::ST_IDLE: begin
                if (on && start) begin
                    s_nxt.c1[sat_pkg::C1_GO] = 1'b0;
                    if (s_r.gap == 9'h000) begin
                        s_nxt.gap = min_gap;
                        s_nxt.tadc = 5'h00;
                        s_nxt.sample = 1'b1;
                        s_nxt.fsm = sat_pkg::ST_SAMPLE;
                    end else if (trig_src != sat_pkg::TRIG_AUTO) begin
                        s_nxt.st[sat_pkg::ST_EARLY] = 1'b1;
                    end
                end
            end
            sat_pkg::ST_SAMPLE: begin
                if (conversion_clock_period) begin
                    if (trig_src != sat_pkg::TRIG_AUTO ||
                        s_r.tadc >= s_r.c3[sat_pkg::C3_AUTO_SAMPLE_TIME +: 5]) begin
                        s_nxt.sample = 1'b0;
                        s_nxt.convert = 1'b1;
                        s_nxt.tadc = 5'h00;
                        s_nxt.fsm = sat_pkg::ST_CONV;
                    end else begin
                        s_nxt.tadc = s_r.tadc + 5'h01;
                    end
                end
            end
            sat_pkg::ST_CONV: begin
                if (conversion_clock_period) begin
                    s_nxt.tadc = s_r.tadc + 5'h01;
                    if (s_r.tadc == conv_len - 5'h01) begin
                        s_nxt.convert = 1'b0;
                        s_nxt.fsm = sat_pkg::ST_STORE;
                    end
                end
            end
            sat_pkg::ST_STORE: begin
                s_nxt.rbuf[s_r.widx] = fmt(conv_result_i, r12,
                    s_r.c1[sat_pkg::C1_FMT +: 2]);
                s_nxt.widx = s_r.widx + 4'h1;
                if ({1'b0, s_r.shi} + 3'h1 < nsh) begin
                    s_nxt.shi = s_r.shi + 2'h1;
                    s_nxt.tadc = 5'h00;
                    s_nxt.convert = 1'b1;
                    s_nxt.fsm = sat_pkg::ST_CONV;
                end else begin
                    s_nxt.shi = 2'h0;
                    s_nxt.fsm = sat_pkg::ST_IDLE;
                    if (s_r.nsmp == s_r.c2[sat_pkg::C2_SMPI +: 4]) begin
                        s_nxt.nsmp = 4'h0;
                        s_nxt.widx = 4'h0;
                        s_nxt.st[sat_pkg::ST_DONE] = 1'b1;
                    end else begin
                        s_nxt.nsmp = s_r.nsmp + 4'h1;
                    end
                end
            end
        endcase
        if (!on) begin
            s_nxt.fsm = sat_pkg::ST_IDLE;
            s_nxt.sample = 1'b0;
            s_nxt.convert = 1'b0;
            s_nxt.shi = 2'h0;
            s_nxt.tadc = 5'h00;
        end
        s_nxt.shc = s_nxt.c1[sat_pkg::C1_RES] ? 2'h0
            : s_nxt.c2[sat_pkg::C2_SHC +: 2];
        s_nxt.irq = |(s_nxt.st & s_nxt.mask);

        if (rst_i) begin
            s_nxt = '0;
            s_nxt.fsm = sat_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////

    assign wb_dat_o = s_r.rdat;
    assign wb_ack_o = s_r.ack;
    assign irq_o = s_r.irq;
    assign sample_o = s_r.sample;
    assign convert_o = s_r.convert;
    assign conv_sh_o = s_r.shi;
    assign sh_count_o = s_r.shc;
    assign chan_sel_o = s_r.chs[3:0];
    assign vref_sel_o = s_r.c2[sat_pkg::C2_VREF +: 3];
    assign res12_o = s_r.c1[sat_pkg::C1_RES];
    assign pin_digital_o = s_r.pl[9:0];
endmodule

//--- logic/sat_pkg.sv
// Constants, state encodings and the conversion clock generator of the
// converter timing block.
// Assumes one 200 MHz clock, equal to the instruction cycle, and a sync reset.
// Notes on behaviour
// - Control 3 bit 15 set picks the internal RC clock, else system clock.
// - System clock mode: period is one cycle times divider plus one, divider held to 63 at most.
// - Divider field is ignored while the internal RC clock is selected.
// - Bits 12 to 8 of control 3 give sample time of 0 to 31 periods.
// - Auto sample time applies only when trigger source is 111.
// - 10-bit mode allows 1.1 Msps and up to four inputs sampled together.
// - 12-bit mode: one sample-and-hold, no simultaneous sampling, 500 ksps.
// - Results are written into a sixteen-word result buffer.
// - Ten analog inputs, zero to nine, plus two reference inputs.
// - Vref at ctrl 2 15:13, hold count 9:8; sequence at ctrl 1 7:5.
// - The converter keeps running in processor Sleep and Idle states.
// - Control 1 bit 10 picks 10-bit four-hold or 12-bit one-hold mode.

package sat_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_CTRL3 = 8'h08;
    localparam logic [7:0] OFF_PCFGL = 8'h0C;
    localparam logic [7:0] OFF_PCFGH = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_CHSEL = 8'h1C;
    localparam logic [1:0] BUF_PAGE = 2'h1;
    localparam logic [15:0] REG_RST = 16'h0000;
    // Implemented bits of control 3; bits 14 and 13 read as zero.
    localparam logic [15:0] C3_IMPL = 16'h9fff;
    // Field positions.
    localparam int C1_ON = 15;
    localparam int C1_RES = 10;
    localparam int C1_FMT = 8;
    localparam int C1_TRIG = 5;
    localparam int C1_GO = 1;
    localparam int C2_VREF = 13;
    localparam int C2_SHC = 8;
    localparam int C2_SMPI = 2;
    localparam int C3_RC = 15;
    localparam int C3_AUTO_SAMPLE_TIME = 8;
    localparam int C3_DIV = 0;
    localparam int ST_DONE = 0;
    localparam int ST_EARLY = 1;
    // Trigger sources and limits.
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_EXT = 3'h1;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [7:0] DIV_MAX = 8'h3F;
    localparam logic [3:0] CHAN_MAX = 4'h9;
    localparam logic [4:0] CONV_TAD10 = 5'h0C;
    localparam logic [4:0] CONV_TAD12 = 5'h0E;
    // Rate limits turned into least clock cycles between sample starts.
    localparam int CLK_HZ = 200_000_000;
    localparam int RATE10_SPS = 1_100_000;
    localparam int RATE12_SPS = 500_000;
    localparam int MIN_CYC10 = (CLK_HZ + RATE10_SPS - 1) / RATE10_SPS;
    localparam int MIN_CYC12 = (CLK_HZ + RATE12_SPS - 1) / RATE12_SPS;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONV = 4'b0100,
        ST_STORE = 4'b1000
    } sat_fsm_e;
endpackage

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module sat_tad_gen (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration.
    input wire logic run_i,
    input wire logic rc_sel_i,
    input wire logic [7:0] div_i,
    input wire logic rc_tick_i,
    // One pulse per conversion clock period.
    output logic tad_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic conversion_clock_period;
    } sat_tad_s;

    sat_tad_s s_r;
    sat_tad_s s_nxt;
    logic [7:0] lim;

    always_comb begin
        s_nxt = s_r;
        lim = (div_i > sat_pkg::DIV_MAX) ? sat_pkg::DIV_MAX : div_i;
        s_nxt.conversion_clock_period = 1'b0;
        if (!run_i) begin
            s_nxt.cnt = 8'h00;
        end else if (rc_sel_i) begin
            s_nxt.cnt = 8'h00;
            s_nxt.conversion_clock_period = rc_tick_i;
        end else if (s_r.cnt >= lim) begin
            s_nxt.cnt = 8'h00;
            s_nxt.conversion_clock_period = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
        if (rst_i) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign tad_o = s_r.conversion_clock_period;
endmodule

//--- testbench/sat_adc_ctrl_properties.sv
// Concurrent checks on the ports of the converter timing block.
// Assumes the single clock clk_i and the synchronous reset rst_i.
`timescale 1ns/1ps
module sat_adc_props (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Front end.
    input wire logic sample_o,
    input wire logic convert_o,
    input wire logic [1:0] conv_sh_o,
    input wire logic [1:0] sh_count_o,
    input wire logic [3:0] chan_sel_o,
    input wire logic res12_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack not one cycle after request");
    unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
        && !wb_ack_o && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    phase_excl_a: assert property (!(sample_o && convert_o))
        else $error("sample and convert together");
    conv_start_a: assert property ($rose(convert_o) |->
        ($past(sample_o) || conv_sh_o != 2'h0) ##1 convert_o [*8])
        else $error("conversion start wrong");
    single_sh_a: assert property (res12_o |-> sh_count_o == 2'h0
        && conv_sh_o == 2'h0) else $error("several holds in 12-bit mode");
    chan_range_a: assert property (chan_sel_o <= 4'h9)
        else $error("channel above nine");
endmodule
bind sat_adc_ctrl sat_adc_props i_props (.*);

//--- testbench/sat_front_model.sv
// Analog front end model: free running RC tick and a result word.
// Assumes the block takes the result in the cycle after convert falls.
`timescale 1ns/1ps
module sat_front_model #(
    parameter int RC_PER = 10
) (
    // Clock.
    input wire logic clk_i,
    // Front end control.
    input wire logic convert_i,
    input wire logic [3:0] chan_i,
    // Tick and result.
    output logic rc_tick_o,
    output logic [11:0] result_o
);
    int cnt = 0;
    logic conv_d = 1'b0;
    logic [11:0] val;
    ////////////////////////////////////////
    always @(posedge clk_i) begin
        cnt <= (cnt >= RC_PER - 1) ? 0 : cnt + 1;
        conv_d <= convert_i;
    end
    assign rc_tick_o = (cnt == RC_PER - 1);
    assign val = 12'ha50 | {8'h00, chan_i};
    // Outside the store cycle the lines show the inverse value.
    assign result_o = (conv_d && !convert_i) ? val : ~val;
endmodule

//--- testbench/test_sat_adc_ctrl.sv
// Self-checking bench of the converter timing block over Wishbone.
// Assumes the front end model and the bound port checker.
`timescale 1ns/1ps
module test_sat_adc_ctrl;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic trig_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, rc_tick_i, sample_o, convert_o, res12_o;
    logic [11:0] conv_result_i;
    logic [1:0] conv_sh_o, sh_count_o;
    logic [3:0] chan_sel_o;
    logic [2:0] vref_sel_o;
    logic [9:0] pin_digital_o;
    logic [31:0] q;
    int err_count = 0;
    int checks_done = 0;
    int s, c;
    sat_adc_ctrl i_dut (.*);
    sat_front_model i_fe (.clk_i(clk_i), .convert_i(convert_o),
        .chan_i(chan_sel_o), .rc_tick_o(rc_tick_i),
        .result_o(conv_result_i));
    ////////////////////////////////////////
    initial forever #2.5 clk_i = ~clk_i;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, logic [15:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // Runs one sequence and measures the sample and convert lengths.
    task automatic conv(input logic [15:0] c1, output int s, output int c);
        int n;
        repeat (400) @(posedge clk_i);
        xfer(1, sat_pkg::OFF_CTRL1, c1);
        xfer(1, sat_pkg::OFF_CTRL1, c1 | 16'h8000);
        if (c1[7:5] == 3'h0) xfer(1, sat_pkg::OFF_CTRL1, c1 | 16'h8002);
        if (c1[7:5] == 3'h1) begin
            @(posedge clk_i);
            trig_i <= 1'b1;
            @(posedge clk_i);
            trig_i <= 1'b0;
        end
        n = 0;
        while (sample_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        s = 0;
        c = 0;
        while (sample_o === 1'b1 && s < 1000) begin
            @(posedge clk_i);
            s++;
        end
        while (convert_o === 1'b1 && c < 1000) begin
            @(posedge clk_i);
            c++;
        end
        repeat (4) @(posedge clk_i);
        xfer(1, sat_pkg::OFF_CTRL1, c1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(0, sat_pkg::OFF_CTRL3, 16'h0000);
        check("ctrl3 reset", q, {16'h0000, sat_pkg::REG_RST});
        xfer(1, sat_pkg::OFF_CTRL3, 16'hffff);
        xfer(0, sat_pkg::OFF_CTRL3, 16'h0000);
        check("ctrl3 bits", q, 32'h0000_9fff);
        xfer(0, 8'h20, 16'h0000);
        check("unmapped", q, 32'h0000_0000);
        xfer(1, sat_pkg::OFF_CHSEL, 16'h000f);
        check("chan clamp", chan_sel_o, 4'h9);
        xfer(1, sat_pkg::OFF_PCFGL, 16'h03ff);
        check("pin config", pin_digital_o, 10'h3ff);
        xfer(1, sat_pkg::OFF_CTRL2, 16'ha300);
        check("vref", vref_sel_o, 3'h5);
        check("sh count", sh_count_o, 2'h3);
        xfer(1, sat_pkg::OFF_CTRL2, 16'ha000);
        // Divider 3 and sample time 4; reserved divider codes never used.
        xfer(1, sat_pkg::OFF_CTRL3, 16'h0403);
        conv(16'h0000, s, c);
        check("manual sample", s <= 4, 1'b1);
        check("convert len", c, 48);
        check("masked irq", irq_o, 1'b0);
        conv(16'h0020, s, c);
        check("ext convert len", c, 48);
        conv(16'h0200, s, c);
        xfer(0, 8'h40, 16'h0000);
        check("frac word", q, 32'h0000_9640);
        conv(16'h00e0, s, c);
        check("auto sample", s >= 15 && s <= 20, 1'b1);
        xfer(1, sat_pkg::OFF_CTRL3, 16'h8403);
        conv(16'h0000, s, c);
        check("rc convert len", c, 120);
        xfer(1, sat_pkg::OFF_CTRL3, 16'h0003);
        xfer(0, sat_pkg::OFF_STAT, 16'h0000);
        xfer(1, sat_pkg::OFF_MASK, 16'h0001);
        conv(16'h0400, s, c);
        check("12b convert len", c, 56);
        check("irq raised", irq_o, 1'b1);
        xfer(0, sat_pkg::OFF_STAT, 16'h0000);
        check("status", q, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        check("irq cleared", irq_o, 1'b0);
        xfer(0, 8'h40, 16'h0000);
        check("buffer word", q, 32'h0000_0a59);
        xfer(1, sat_pkg::OFF_CTRL2, 16'ha300);
        check("12b sh count", sh_count_o, 2'h0);
        xfer(1, sat_pkg::OFF_CTRL1, 16'h8400);
        xfer(1, sat_pkg::OFF_CTRL1, 16'h8000);
        check("res locked", res12_o, 1'b1);
        tally_and_finish();
    end
endmodule
